// ==== bench/adc_result_monitor_tb.sv ====
// self-checking bench for the converter result monitor
`timescale 1ns/1ps
`include "adm_params.svh"
module adc_result_monitor_tb
  import adm_pkg::*;
;
  typedef struct packed {
    logic       dir;
    logic [3:0] sel;
    logic       en;
    logic [3:0] slot;
    logic [9:0] data;
    logic       hit;
  } adm_row_t;

  logic        clk;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        conv_valid;
  logic [3:0]  conv_slot;
  logic [9:0]  conv_data;
  logic [9:0]  cmp_value;
  logic        mon_pulse;
  logic        irq;
  logic        req;
  logic        slow;
  logic [3:0]  req_slot;
  logic [9:0]  req_data;
  logic [31:0] rd_val;
  int          err_total;
  int          total_checks;
  int          cycles;
  // comparison value is 0x200 for the table; rows sit on both sides of it and on it
  adm_row_t    rows [0:11] = '{
    '{0, 0, 0, 0, 10'h010, 0}, '{0, 0, 1, 0, 10'h010, 1}, '{0, 0, 1, 0, 10'h1ff, 1},
    '{0, 0, 1, 0, 10'h200, 0}, '{0, 0, 1, 0, 10'h201, 0}, '{1, 1, 1, 1, 10'h201, 1},
    '{1, 1, 1, 1, 10'h200, 0}, '{1, 1, 1, 1, 10'h1ff, 0}, '{1, 1, 1, 0, 10'h3ff, 0},
    '{1, 3, 1, 4, 10'h3ff, 0}, '{1, 8, 1, 15, 10'h3ff, 1}, '{1, 12, 1, 9, 10'h3ff, 1}};
  logic [7:0]  addrs [0:5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

  adm_monitor #(.RES_W(10)) dut_u (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
    .conv_slot(conv_slot), .conv_data(conv_data), .cmp_value(cmp_value),
    .mon_pulse(mon_pulse), .irq(irq));

  adm_conv_model #(.RES_W(10)) core_u (
    .clk(clk), .arst_n(arst_n), .req(req), .slow(slow), .req_slot(req_slot),
    .req_data(req_data), .conv_valid(conv_valid), .conv_slot(conv_slot),
    .conv_data(conv_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // returns in the cycle after the landing, where the monitor pulse stands
  task automatic send(input logic [3:0] s, input logic [9:0] d, input logic w);
    @(posedge clk);
    req      <= 1'b1;
    req_slot <= s;
    req_data <= d;
    slow     <= w;
    @(posedge clk);
    req <= 1'b0;
    if (w) begin
      @(posedge clk);
    end
    @(posedge clk);
    #1;
  endtask : send

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    arst_n    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cmp_value = 10'h200;
    req       = 1'b0;
    slow      = 1'b0;
    req_slot  = 4'h0;
    req_data  = 10'h000;
    err_total = 0;
    total_checks = 0;
    cycles    = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    foreach (addrs[k]) begin
      rd(addrs[k]);
      chk("reset value", 32'h0, rd_val);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      wr(`ADM_OFF_CTRL, {26'h0, rows[i].dir, rows[i].sel, rows[i].en});
      send(rows[i].slot, rows[i].data, 1'b0);
      chk("monitor pulse", {31'h0, rows[i].hit}, {31'h0, mon_pulse});
    end
    for (int c = 0; c < 16; c++) begin
      wr(`ADM_OFF_CTRL, 32'h21 | (c << 1));
      send(4'(c), 10'h3ff, 1'b0);
      chk("target code", 32'h1, {31'h0, mon_pulse});
    end
    $display("monitor table done");
    // nothing unmasked yet, so the sticky bits must not reach irq
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(`ADM_OFF_STATUS);
    chk("status", 32'h7, rd_val);
    rd(`ADM_OFF_SLOT0);
    chk("slot0", 32'h0000ffc3, rd_val);
    rd(`ADM_OFF_SLOT0);
    chk("slot0 reread", 32'h0000ffc0, rd_val);
    rd(`ADM_OFF_SLOT1);
    chk("slot1", 32'h0000ffc3, rd_val);
    wr(`ADM_OFF_MASK, 32'h7);
    settle();
    chk("irq set", 32'h1, {31'h0, irq});
    wr(`ADM_OFF_STATUS, 32'h1);
    settle();
    chk("irq partly cleared", 32'h1, {31'h0, irq});
    wr(`ADM_OFF_STATUS, 32'h6);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("interrupt test done");
    wr(`ADM_OFF_MASK, 32'h1);
    wr(`ADM_OFF_CTRL, 32'h0);
    send(4'h0, 10'h010, 1'b1);
    rd(`ADM_OFF_STATUS);
    chk("status disabled", 32'h0, rd_val);
    rd(`ADM_OFF_SLOT0);
    chk("slot0 slow", 32'h00000401, rd_val);
    wr(`ADM_OFF_SLOT0, 32'hffffffff);
    rd(`ADM_OFF_SLOT0);
    chk("slot0 after write", 32'h00000400, rd_val);
    wr(`ADM_OFF_CTRL, 32'h1);
    send(4'h0, 10'h010, 1'b0);
    chk("hit pulse", 32'h1, {31'h0, mon_pulse});
    @(posedge clk);
    #1;
    chk("pulse length", 32'h0, {31'h0, mon_pulse});
    @(posedge clk);
    #1;
    chk("irq on hit", 32'h1, {31'h0, irq});
    wr(`ADM_OFF_STATUS, 32'h1);
    settle();
    chk("irq after clear", 32'h0, {31'h0, irq});
    $display("enable test done");
    // back-to-back landings without a read in between
    send(4'h1, 10'h0aa, 1'b0);
    send(4'h1, 10'h2cc, 1'b0);
    rd(`ADM_OFF_SLOT1);
    chk("slot1 overrun", 32'h0000b303, rd_val);
    wr(`ADM_OFF_CTRL, 32'hffffffff);
    rd(`ADM_OFF_CTRL);
    chk("control fields", 32'h0000003f, rd_val);
    $display("overrun test done");
    // two reads with no gap: the second already sees the stored flag cleared
    send(4'h1, 10'h155, 1'b0);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= `ADM_OFF_SLOT1;
    @(posedge clk);
    #1 rd_val = reg_rdata;
    chk("slot1 first read", 32'h00005541, rd_val);
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk("slot1 second read", 32'h00005540, rd_val);
    // a result that only beats the moved threshold
    wr(`ADM_OFF_CTRL, 32'h21);
    cmp_value <= 10'h0f0;
    send(4'h0, 10'h0f1, 1'b0);
    chk("new threshold", 32'h1, {31'h0, mon_pulse});
    $display("back-to-back and threshold test done");
    // reset in mid-run clears pulse, slots and control at once
    arst_n <= 1'b0;
    #1;
    chk("pulse in reset", 32'h0, {31'h0, mon_pulse});
    @(posedge clk);
    arst_n <= 1'b1;
    rd(`ADM_OFF_SLOT0);
    chk("slot0 after reset", 32'h0, rd_val);
    rd(`ADM_OFF_CTRL);
    chk("control after reset", 32'h0, rd_val);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : adc_result_monitor_tb

// ==== bench/adm_conv_model.sv ====
// converter core stand-in: lands one result per bench request, promptly or one cycle late
`timescale 1ns/1ps
module adm_conv_model
  import adm_pkg::*;
#(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // request from the bench
  input  wire logic             req,
  input  wire logic             slow,
  input  wire logic [3:0]       req_slot,
  input  wire logic [RES_W-1:0] req_data,
  // result toward the monitor
  output logic                  conv_valid,
  output logic      [3:0]       conv_slot,
  output logic      [RES_W-1:0] conv_data
);
  logic             pend;
  logic [3:0]       pend_slot;
  logic [RES_W-1:0] pend_data;

  // a slow answer parks the request for one extra cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend      <= 1'b0;
      pend_slot <= '0;
      pend_data <= '0;
    end else begin
      pend <= req && slow;
      if (req) begin
        pend_slot <= req_slot;
        pend_data <= req_data;
      end
    end
  end

  // between landings the bus is not held: it flips every cycle, so a design
  // that samples it without conv_valid sees noise rather than a stale match
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_valid <= 1'b0;
      conv_slot  <= '0;
      conv_data  <= '0;
    end else if (req && !slow) begin
      conv_valid <= 1'b1;
      conv_slot  <= req_slot;
      conv_data  <= req_data;
    end else if (pend) begin
      conv_valid <= 1'b1;
      conv_slot  <= pend_slot;
      conv_data  <= pend_data;
    end else begin
      conv_valid <= 1'b0;
      conv_slot  <= ~conv_slot;
      conv_data  <= ~conv_data;
    end
  end
endmodule : adm_conv_model

// ==== common/adm_params.svh ====
// constants of the converter result monitor: offsets, fields, reset values
`ifndef ADM_PARAMS_SVH
`define ADM_PARAMS_SVH

`define ADM_ADDR_W      8
`define ADM_DATA_W      32
`define ADM_RES_W       10

`define ADM_OFF_CTRL    8'h00
`define ADM_OFF_SLOT0   8'h04
`define ADM_OFF_SLOT1   8'h08
`define ADM_OFF_STATUS  8'h0c
`define ADM_OFF_MASK    8'h10

`define ADM_CTRL_EN     0
`define ADM_CTRL_SEL_LO 1
`define ADM_CTRL_SEL_HI 4
`define ADM_CTRL_DIR    5
`define ADM_SEL_PRIO    3

`define ADM_RES_LO      6
`define ADM_OVR_BIT     1
`define ADM_STORED_BIT  0

`define ADM_SLOT_ZERO   4'h0
`define ADM_SLOT_ONE    4'h1

`define ADM_IRQ_MON     0
`define ADM_IRQ_OVERRUN_FLAG_ZERO    1
`define ADM_IRQ_OVERRUN_FLAG_ONE    2
`define ADM_IRQ_W       3

`define ADM_CTRL_RST    6'h00
`define ADM_IRQ_RST     3'h0

`endif

// ==== common/adm_pkg.sv ====
// types shared by the converter result monitor
package adm_pkg;
  typedef enum logic {
    adm_below = 1'b0,
    adm_above = 1'b1
  } adm_dir_t;

  typedef logic [3:0] adm_slot_t;
endpackage : adm_pkg

// ==== verilog/adm_monitor.sv ====
// converter result slots 0 and 1 with threshold monitor channel 1
`timescale 1ns/1ps
`include "adm_params.svh"
module adm_monitor
  import adm_pkg::*;
#(
  parameter int RES_W = `ADM_RES_W
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // register port
  input  wire logic [`ADM_ADDR_W-1:0] reg_addr,
  input  wire logic [`ADM_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`ADM_DATA_W-1:0] reg_rdata,
  // converter core results, same clock
  input  wire logic                   conv_valid,
  input  wire logic [3:0]             conv_slot,
  input  wire logic [RES_W-1:0]       conv_data,
  // comparison value 1 from its own register
  input  wire logic [RES_W-1:0]       cmp_value,
  // events
  output logic                        mon_pulse,
  output logic                        irq
);
  // the read-data packing has room for 26 result bits; this check allows ten only
  if (RES_W < 1 || RES_W > 10) begin : g_width_check
    $error("RES_W must lie between 1 and 10");
  end

  localparam int PAD_W = `ADM_DATA_W - `ADM_RES_LO - RES_W;
  // a literal cannot be sliced, so the reset image gets a name first
  localparam logic [5:0] CTRL_RST = `ADM_CTRL_RST;

  // control register fields
  logic                   monitor_enable;
  adm_slot_t              monitor_target_select;
  adm_dir_t               monitor_direction;

  // result slots
  logic [RES_W-1:0]       result_value_zero;
  logic [RES_W-1:0]       result_value_one;
  logic                   stored_flag_zero;
  logic                   stored_flag_one;
  logic                   overrun_flag_zero;
  logic                   overrun_flag_one;

  // interrupt block
  logic [`ADM_IRQ_W-1:0]  irq_status;
  logic [`ADM_IRQ_W-1:0]  irq_mask;
  logic [`ADM_IRQ_W-1:0]  next_irq_status;
  logic [`ADM_IRQ_W-1:0]  next_irq_mask;
  logic [`ADM_IRQ_W-1:0]  irq_set;

  // decoded accesses
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   wr_mask;
  logic                   rd_slot0;
  logic                   rd_slot1;

  // converter side
  logic                   land0;
  logic                   land1;
  logic                   target_match;
  logic                   below_hit;
  logic                   above_hit;
  logic                   cond_hit;
  logic                   mon_hit;
  logic                   overrun_flag_zero_event;
  logic                   overrun_flag_one_event;
  logic [`ADM_DATA_W-1:0] next_rdata;

  assign wr_ctrl   = reg_wr && reg_addr == `ADM_OFF_CTRL;
  assign wr_status = reg_wr && reg_addr == `ADM_OFF_STATUS;
  assign wr_mask   = reg_wr && reg_addr == `ADM_OFF_MASK;
  assign rd_slot0  = reg_rd && reg_addr == `ADM_OFF_SLOT0;
  assign rd_slot1  = reg_rd && reg_addr == `ADM_OFF_SLOT1;

  assign land0 = conv_valid && conv_slot == `ADM_SLOT_ZERO;
  assign land1 = conv_valid && conv_slot == `ADM_SLOT_ONE;

  // control register: six writable bits, the rest read as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      monitor_enable        <= CTRL_RST[`ADM_CTRL_EN];
      monitor_target_select <= CTRL_RST[`ADM_CTRL_SEL_HI:`ADM_CTRL_SEL_LO];
      monitor_direction     <= adm_dir_t'(CTRL_RST[`ADM_CTRL_DIR]);
    end else if (wr_ctrl) begin
      monitor_enable        <= reg_wdata[`ADM_CTRL_EN];
      monitor_target_select <= reg_wdata[`ADM_CTRL_SEL_HI:`ADM_CTRL_SEL_LO];
      monitor_direction     <= adm_dir_t'(reg_wdata[`ADM_CTRL_DIR]);
    end
  end

  // result slots 0 and 1; the other targets are watched on the result bus only
  adm_result_slot #(
    .RES_W     (RES_W)
  ) u_slot0 (
    .clk       (clk),
    .arst_n    (arst_n),
    .land      (land0),
    .land_data (conv_data),
    .rd_hit    (rd_slot0),
    .value     (result_value_zero),
    .stored    (stored_flag_zero),
    .overrun   (overrun_flag_zero)
  );

  adm_result_slot #(
    .RES_W     (RES_W)
  ) u_slot1 (
    .clk       (clk),
    .arst_n    (arst_n),
    .land      (land1),
    .land_data (conv_data),
    .rd_hit    (rd_slot1),
    .value     (result_value_one),
    .stored    (stored_flag_one),
    .overrun   (overrun_flag_one)
  );

  // overrun events mirror the slot's own set condition
  assign overrun_flag_zero_event = land0 && stored_flag_zero && !rd_slot0;
  assign overrun_flag_one_event = land1 && stored_flag_one && !rd_slot1;

  // any code with the top bit set means any priority register, slots 8 to 15
  always_comb begin
    if (monitor_target_select[`ADM_SEL_PRIO]) begin
      target_match = conv_slot[`ADM_SEL_PRIO];
    end else begin
      target_match = conv_slot == monitor_target_select;
    end
  end

  // comparison is strict: an equal result never hits
  assign below_hit = conv_data < cmp_value;
  assign above_hit = conv_data > cmp_value;
  assign cond_hit  = (monitor_direction == adm_above) ? above_hit : below_hit;

  // evaluated only on a fresh result in the chosen register
  assign mon_hit = monitor_enable && conv_valid && target_match && cond_hit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_pulse <= 1'b0;
    end else begin
      mon_pulse <= mon_hit;
    end
  end

  // sticky status, write one to clear; a new event beats a clear in the same cycle
  assign irq_set[`ADM_IRQ_MON]  = mon_hit;
  assign irq_set[`ADM_IRQ_OVERRUN_FLAG_ZERO] = overrun_flag_zero_event;
  assign irq_set[`ADM_IRQ_OVERRUN_FLAG_ONE] = overrun_flag_one_event;

  always_comb begin
    next_irq_status = irq_status;
    if (wr_status) begin
      next_irq_status = irq_status & ~reg_wdata[`ADM_IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_set;
  end

  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_mask) begin
      next_irq_mask = reg_wdata[`ADM_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= `ADM_IRQ_RST;
      irq_mask   <= `ADM_IRQ_RST;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  // built from next values so the level lines up with status and mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

  // read mux; flags are sampled before the read-clear lands
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `ADM_OFF_CTRL: begin
          next_rdata[`ADM_CTRL_EN]                        = monitor_enable;
          next_rdata[`ADM_CTRL_SEL_HI:`ADM_CTRL_SEL_LO]   = monitor_target_select;
          next_rdata[`ADM_CTRL_DIR]                       = monitor_direction;
        end
        `ADM_OFF_SLOT0: begin
          next_rdata = {{PAD_W{1'b0}}, result_value_zero, 4'h0,
                        overrun_flag_zero, stored_flag_zero};
        end
        `ADM_OFF_SLOT1: begin
          next_rdata = {{PAD_W{1'b0}}, result_value_one, 4'h0,
                        overrun_flag_one, stored_flag_one};
        end
        `ADM_OFF_STATUS: begin
          next_rdata[`ADM_IRQ_W-1:0] = irq_status;
        end
        `ADM_OFF_MASK: begin
          next_rdata[`ADM_IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // data stand for exactly the cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  enable_gate_a: assert property (
    !monitor_enable |=> !mon_pulse && !$rose(irq_status[`ADM_IRQ_MON]))
    else $error("monitor fired while disabled");

  below_hit_a: assert property (
    monitor_enable && conv_valid && target_match && monitor_direction == adm_below
    && conv_data < cmp_value |=> mon_pulse && irq_status[`ADM_IRQ_MON])
    else $error("below condition missed");

  above_hit_a: assert property (
    monitor_enable && conv_valid && target_match && monitor_direction == adm_above
    && conv_data <= cmp_value |=> !mon_pulse)
    else $error("above condition fired without a larger result");

  prio_select_a: assert property (
    conv_valid && monitor_target_select[`ADM_SEL_PRIO] && !conv_slot[`ADM_SEL_PRIO]
    |=> !mon_pulse)
    else $error("ordinary slot matched a priority target");

  slot_match_a: assert property (
    monitor_enable && conv_valid && !monitor_target_select[`ADM_SEL_PRIO]
    && conv_slot != monitor_target_select |=> !mon_pulse)
    else $error("unselected register was monitored");

  write_ignored_a: assert property (
    reg_wr && reg_addr == `ADM_OFF_SLOT0 && !land0 |=> $stable(result_value_zero))
    else $error("bus write changed a result value");

  ovr_irq_a: assert property (
    land1 && stored_flag_one && !rd_slot1 |=> overrun_flag_one && irq_status[`ADM_IRQ_OVERRUN_FLAG_ONE])
    else $error("overrun of slot one not flagged");

  read_clear_a: assert property (
    rd_slot0 && !land0 |=> !overrun_flag_zero && !stored_flag_zero
    && reg_rdata[`ADM_OVR_BIT] == $past(overrun_flag_zero))
    else $error("read of slot zero did not return then clear flags");

  stored_read_a: assert property (
    land0 ##1 rd_slot0 |=> reg_rdata[`ADM_STORED_BIT])
    else $error("stored flag not visible after a result");

  stored_clear_a: assert property (
    rd_slot1 && !land1 ##1 reg_rd && reg_addr == `ADM_OFF_SLOT1 && !land1
    |=> !reg_rdata[`ADM_STORED_BIT])
    else $error("stored flag survived a read");

  pulse_len_a: assert property (
    mon_pulse |-> $past(conv_valid) && $past(monitor_enable))
    else $error("monitor pulse without a fresh result");

  pulse_once_a: assert property (
    !conv_valid |=> !mon_pulse)
    else $error("monitor pulse outlasted its result");

  above_fire_a: assert property (
    monitor_enable && conv_valid && target_match && monitor_direction == adm_above
    && conv_data > cmp_value |=> mon_pulse && irq_status[`ADM_IRQ_MON])
    else $error("above condition missed");

  prio_fire_a: assert property (
    monitor_enable && conv_valid && monitor_target_select[`ADM_SEL_PRIO]
    && conv_slot[`ADM_SEL_PRIO] && cond_hit |=> mon_pulse)
    else $error("priority target result not monitored");

  ctrl_write_a: assert property (
    wr_ctrl |=> monitor_enable == $past(reg_wdata[`ADM_CTRL_EN])
    && monitor_target_select == $past(reg_wdata[`ADM_CTRL_SEL_HI:`ADM_CTRL_SEL_LO]))
    else $error("control write not taken");

  dir_write_a: assert property (
    wr_ctrl |=> monitor_direction == adm_dir_t'($past(reg_wdata[`ADM_CTRL_DIR])))
    else $error("direction write not taken");

  slot0_read_a: assert property (
    rd_slot0 |=> reg_rdata[`ADM_RES_LO +: RES_W] == $past(result_value_zero))
    else $error("slot zero read returned a wrong result");

  slot1_read_a: assert property (
    rd_slot1 |=> reg_rdata[`ADM_RES_LO +: RES_W] == $past(result_value_one))
    else $error("slot one read returned a wrong result");

  slot_pad_a: assert property (
    rd_slot0 || rd_slot1 |=> reg_rdata[`ADM_DATA_W-1:`ADM_RES_LO+RES_W] == '0
    && reg_rdata[`ADM_RES_LO-1:`ADM_OVR_BIT+1] == '0)
    else $error("unused slot bits read as nonzero");

  overrun_flag_zero_irq_a: assert property (
    land0 && stored_flag_zero && !rd_slot0
    |=> overrun_flag_zero && irq_status[`ADM_IRQ_OVERRUN_FLAG_ZERO])
    else $error("overrun of slot zero not flagged");

  // interrupt bookkeeping: sticky until a write of one
  status_hold_a: assert property (
    !wr_status |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit dropped without a clear");

  status_clear_a: assert property (
    wr_status && reg_wdata[`ADM_IRQ_MON] && !mon_hit |=> !irq_status[`ADM_IRQ_MON])
    else $error("write one did not clear the monitor status bit");

  mask_write_a: assert property (
    wr_mask |=> irq_mask == $past(reg_wdata[`ADM_IRQ_W-1:0]))
    else $error("mask write not taken");

  irq_level_a: assert property (
    irq == |(irq_status & irq_mask))
    else $error("interrupt line disagrees with status and mask");

  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside the answer cycle");

  mon_hit_c: cover property (mon_pulse ##1 irq);
  overrun_c: cover property (land0 ##[1:4] land0 ##1 overrun_flag_zero);
  set_clear_c: cover property (wr_status && |irq_set);
  prio_c: cover property (mon_hit && monitor_target_select[`ADM_SEL_PRIO]);
  back_read_c: cover property (rd_slot1 ##1 rd_slot1);
endmodule : adm_monitor

// ==== verilog/adm_result_slot.sv ====
// one conversion result register with its stored and overrun flags
`timescale 1ns/1ps
`include "adm_params.svh"
module adm_result_slot
  import adm_pkg::*;
#(
  parameter int RES_W = `ADM_RES_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // result from the converter core
  input  wire logic             land,
  input  wire logic [RES_W-1:0] land_data,
  // software read of this register
  input  wire logic             rd_hit,
  // held state
  output logic      [RES_W-1:0] value,
  output logic                  stored,
  output logic                  overrun
);
  logic next_stored;
  logic next_overrun;
  logic ovr_set;

  // a read in the same cycle as the overwrite fetched the old value, so no overrun
  assign ovr_set = land && stored && !rd_hit;

  // no bus write path exists: only the converter loads the value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value <= '0;
    end else if (land) begin
      value <= land_data;
    end
  end

  // set wins over the read-clear
  always_comb begin
    next_stored = stored;
    if (land) begin
      next_stored = 1'b1;
    end else if (rd_hit) begin
      next_stored = 1'b0;
    end
  end

  always_comb begin
    next_overrun = overrun;
    if (ovr_set) begin
      next_overrun = 1'b1;
    end else if (rd_hit) begin
      next_overrun = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stored  <= 1'b0;
      overrun <= 1'b0;
    end else begin
      stored  <= next_stored;
      overrun <= next_overrun;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  value_hold_a: assert property (!land |=> $stable(value))
    else $error("result value changed without a new result");
  ovr_set_a: assert property (land && stored && !rd_hit |=> overrun)
    else $error("overwrite of unread result did not set overrun");
  ovr_clr_a: assert property (rd_hit && !land |=> !overrun)
    else $error("read did not clear overrun");
  stored_set_a: assert property (land |=> stored && value == $past(land_data))
    else $error("landing result not stored");
  stored_clr_a: assert property (rd_hit && !land |=> !stored)
    else $error("read did not clear stored flag");
endmodule : adm_result_slot
